// >>> tobd_defs.svh
`ifndef TOBD_DEFS_SVH
`define TOBD_DEFS_SVH
`define TOBD_ADDR_W          8
`define TOBD_OFF_HOST_A      8'h06
`define TOBD_OFF_HOST_B      8'h07
`define TOBD_OFF_HOST_C      8'h08
`define TOBD_OFF_HOST_D      8'h09
`define TOBD_OFF_UNFIN       8'h0A
`define TOBD_OFF_REFUSED     8'h0B
`define TOBD_OFF_GAP         8'h0C
`define TOBD_OFF_GEN_A       8'h0D
`define TOBD_OFF_RANGE       8'h0E
`define TOBD_OFF_EMUL        8'h0F
`define TOBD_OFF_DENS        8'h10
`define TOBD_OFF_LOOKAHEAD   8'h11
`define TOBD_OFF_GEN_B       8'h12
`define TOBD_RST_BYTE        8'h00
`define TOBD_RANGE_BIT       7
`define TOBD_EMUL_HI         6
`define TOBD_EMUL_LO         5
`define TOBD_RAMP_HI         4
`define TOBD_RAMP_LO         3
`define TOBD_RATE_HI         2
`define TOBD_RATE_LO         0
`define TOBD_DENS_ALTHI_BIT  4
`define TOBD_DENS_CMDSET_BIT 3
`define TOBD_DENS_SWAP_BIT   2
`define TOBD_LA_HI           3
`define TOBD_LA_LO           0
`define TOBD_LA_NEVER        8'hFF
`define TOBD_RAMP_2_MS       2
`define TOBD_RAMP_4_MS       4
`define TOBD_RAMP_8_MS       8
`define TOBD_RAMP_120_MS     120
`define TOBD_CLK_KHZ         40000
`define TOBD_HIDEN_STD       5'h18
`define TOBD_HIDEN_ALT       5'h17
`endif

// >>> tobd_pkg.sv
package tobd_pkg;
  typedef enum logic [1:0] {
    TOBD_EMU_STD  = 2'h0,
    TOBD_EMU_ALT1 = 2'h1,
    TOBD_EMU_ALT2 = 2'h2,
    TOBD_EMU_ALT3 = 2'h3
  } tobd_emul_t;
  typedef struct packed {
    logic [7:0]  opt_host_a;
    logic [7:0]  opt_host_b;
    logic [7:0]  opt_host_c;
    logic [7:0]  opt_host_d;
    logic [7:0]  opt_unfin;
    logic [7:0]  opt_refused;
    logic [7:0]  opt_gap;
    logic [7:0]  opt_gen_a;
    logic [7:0]  opt_range;
    logic [7:0]  opt_emul;
    logic [7:0]  opt_dens;
    logic [7:0]  opt_la;
    logic [7:0]  opt_gen_b;
    logic [7:0]  rdata;
    tobd_emul_t  emul;
    logic [23:0] ramp_rd_cyc;
    logic [23:0] ramp_wr_cyc;
    logic [10:0] rate_kbps;
    logic [7:0]  la_stop;
    logic        alt_cmdset;
    logic        pin_swap;
    logic [4:0]  hiden_code;
    logic        mid_dens_ok;
    logic        gen_a_en_low_rate;
  } tobd_state_t;
endpackage : tobd_pkg

// >>> tobd_option_decoder.sv
// Overview of operation
// RL1: bits 6:5 of the emulation byte pick one of four host personalities.
// RL2: bits 4:3 set ramp delay: none, 2 ms, 4 ms, 8/120 ms read/write.
// RL3: bits 2:0 pick one of eight rates; range byte bit 7 picks table.
// RL4: range bit one uses low table, 10 up to 193 kB/s.
// RL5: look-ahead byte keeps only its lower four bits; its upper four bits are unused.
// RL6: look-ahead field zero means 255 file marks, effectively never stops.
// RL7: nonzero field N stops look-ahead after N consecutive marks, max 15.
// RL8: density bit 3 picks standard or alternative encoded command set.
// RL9: density bit 2 swaps speed-select and density-indicator pin assignment.
// RL10: density bit 4 enables alternate highest-density command code.
// RL11: alternate code is 10111 not 11000; third density then unavailable.
// RL12: single-bit options enable their function when one, inactive at zero.
// RL13: decoded outputs are registered and reload whenever a byte is rewritten.
`include "tobd_defs.svh"
module tobd_option_decoder #(
  parameter int CLK_KHZ = `TOBD_CLK_KHZ
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_resetn,
  input  wire logic [`TOBD_ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic [7:0]                    o_rdata,
  output tobd_pkg::tobd_emul_t          o_emulation,
  output logic [23:0]                   o_ramp_read_cycles,
  output logic [23:0]                   o_ramp_write_cycles,
  output logic [10:0]                   o_host_rate_kbps,
  output logic [7:0]                    o_lookahead_stop_marks,
  output logic                          o_alt_command_set,
  output logic                          o_high_speed_select_line_swapped,
  output logic                          o_high_density_indicator_line_swapped,
  output logic [4:0]                    o_highest_density_code,
  output logic                          o_doubled_phase_encoding_allowed,
  output logic                          o_low_rate_range,
  output logic [7:0]                    o_general_options_a,
  output logic [7:0]                    o_general_options_b
);
  localparam logic [23:0] RAMP2_CYC   = 24'(`TOBD_RAMP_2_MS * CLK_KHZ);
  localparam logic [23:0] RAMP4_CYC   = 24'(`TOBD_RAMP_4_MS * CLK_KHZ);
  localparam logic [23:0] RAMP8_CYC   = 24'(`TOBD_RAMP_8_MS * CLK_KHZ);
  localparam logic [23:0] RAMP120_CYC = 24'(`TOBD_RAMP_120_MS * CLK_KHZ);

  tobd_pkg::tobd_state_t state_reg;
  tobd_pkg::tobd_state_t state_next;

  function automatic logic [10:0] rate_lookup(input logic lo_range, input logic [2:0] code);
    logic [10:0] r;
    r = 11'h000;
    if (lo_range) begin // RL4
      unique case (code)
        3'h0: r = 11'h00A;
        3'h1: r = 11'h01E;
        3'h2: r = 11'h032;
        3'h3: r = 11'h048;
        3'h4: r = 11'h064;
        3'h5: r = 11'h078;
        3'h6: r = 11'h09C;
        3'h7: r = 11'h0C1;
      endcase
    end else begin // RL3
      unique case (code)
        3'h0: r = 11'h116;
        3'h1: r = 11'h138;
        3'h2: r = 11'h165;
        3'h3: r = 11'h1A0;
        3'h4: r = 11'h1F4;
        3'h5: r = 11'h271;
        3'h6: r = 11'h341;
        3'h7: r = 11'h4E2;
      endcase
    end
    return r;
  endfunction : rate_lookup

  always_comb begin
    logic [1:0] ramp;
    logic [3:0] la;
    state_next       = state_reg;
    ramp             = 2'h0;
    la               = 4'h0;
    state_next.rdata = 8'h00;
    if (i_wr) begin
      unique case (i_addr)
        `TOBD_OFF_HOST_A:    state_next.opt_host_a  = i_wdata;
        `TOBD_OFF_HOST_B:    state_next.opt_host_b  = i_wdata;
        `TOBD_OFF_HOST_C:    state_next.opt_host_c  = i_wdata;
        `TOBD_OFF_HOST_D:    state_next.opt_host_d  = i_wdata;
        `TOBD_OFF_UNFIN:     state_next.opt_unfin   = i_wdata;
        `TOBD_OFF_REFUSED:   state_next.opt_refused = i_wdata;
        `TOBD_OFF_GAP:       state_next.opt_gap     = i_wdata;
        `TOBD_OFF_GEN_A:     state_next.opt_gen_a   = i_wdata;
        `TOBD_OFF_RANGE:     state_next.opt_range   = i_wdata;
        `TOBD_OFF_EMUL:      state_next.opt_emul    = i_wdata;
        `TOBD_OFF_DENS:      state_next.opt_dens    = i_wdata;
        `TOBD_OFF_LOOKAHEAD: state_next.opt_la      = {4'h0, i_wdata[3:0]}; // RL5
        `TOBD_OFF_GEN_B:     state_next.opt_gen_b   = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        `TOBD_OFF_HOST_A:    state_next.rdata = state_reg.opt_host_a;
        `TOBD_OFF_HOST_B:    state_next.rdata = state_reg.opt_host_b;
        `TOBD_OFF_HOST_C:    state_next.rdata = state_reg.opt_host_c;
        `TOBD_OFF_HOST_D:    state_next.rdata = state_reg.opt_host_d;
        `TOBD_OFF_UNFIN:     state_next.rdata = state_reg.opt_unfin;
        `TOBD_OFF_REFUSED:   state_next.rdata = state_reg.opt_refused;
        `TOBD_OFF_GAP:       state_next.rdata = state_reg.opt_gap;
        `TOBD_OFF_GEN_A:     state_next.rdata = state_reg.opt_gen_a;
        `TOBD_OFF_RANGE:     state_next.rdata = state_reg.opt_range;
        `TOBD_OFF_EMUL:      state_next.rdata = state_reg.opt_emul;
        `TOBD_OFF_DENS:      state_next.rdata = state_reg.opt_dens;
        `TOBD_OFF_LOOKAHEAD: state_next.rdata = state_reg.opt_la;
        `TOBD_OFF_GEN_B:     state_next.rdata = state_reg.opt_gen_b;
        default:             state_next.rdata = 8'h00;
      endcase
    end
    // decode from stored bytes, decoded outputs change two cycles after a write, general option outputs one cycle after
    state_next.emul = tobd_pkg::tobd_emul_t'(
      state_reg.opt_emul[`TOBD_EMUL_HI:`TOBD_EMUL_LO]); // RL1
    ramp = state_reg.opt_emul[`TOBD_RAMP_HI:`TOBD_RAMP_LO];
    unique case (ramp) // RL2
      2'h0: begin
        state_next.ramp_rd_cyc = 24'h000000;
        state_next.ramp_wr_cyc = 24'h000000;
      end
      2'h1: begin
        state_next.ramp_rd_cyc = RAMP2_CYC;
        state_next.ramp_wr_cyc = RAMP2_CYC;
      end
      2'h2: begin
        state_next.ramp_rd_cyc = RAMP4_CYC;
        state_next.ramp_wr_cyc = RAMP4_CYC;
      end
      2'h3: begin
        state_next.ramp_rd_cyc = RAMP8_CYC;
        state_next.ramp_wr_cyc = RAMP120_CYC;
      end
    endcase
    state_next.rate_kbps = rate_lookup(state_reg.opt_range[`TOBD_RANGE_BIT],
      state_reg.opt_emul[`TOBD_RATE_HI:`TOBD_RATE_LO]); // RL3
    state_next.gen_a_en_low_rate = state_reg.opt_range[`TOBD_RANGE_BIT]; // RL12
    la = state_reg.opt_la[`TOBD_LA_HI:`TOBD_LA_LO];
    state_next.la_stop = (la == 4'h0) ? `TOBD_LA_NEVER : {4'h0, la}; // RL6 RL7
    state_next.alt_cmdset  = state_reg.opt_dens[`TOBD_DENS_CMDSET_BIT]; // RL8
    state_next.pin_swap    = state_reg.opt_dens[`TOBD_DENS_SWAP_BIT]; // RL9
    state_next.hiden_code  = state_reg.opt_dens[`TOBD_DENS_ALTHI_BIT] ?
                             `TOBD_HIDEN_ALT : `TOBD_HIDEN_STD; // RL10 RL11
    state_next.mid_dens_ok = !state_reg.opt_dens[`TOBD_DENS_ALTHI_BIT]; // RL11
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next; // RL13
    end
  end

  assign o_rdata                               = state_reg.rdata;
  assign o_emulation                           = state_reg.emul;
  assign o_ramp_read_cycles                    = state_reg.ramp_rd_cyc;
  assign o_ramp_write_cycles                   = state_reg.ramp_wr_cyc;
  assign o_host_rate_kbps                      = state_reg.rate_kbps;
  assign o_lookahead_stop_marks                = state_reg.la_stop;
  assign o_alt_command_set                     = state_reg.alt_cmdset;
  assign o_high_speed_select_line_swapped      = state_reg.pin_swap;
  assign o_high_density_indicator_line_swapped = state_reg.pin_swap;
  assign o_highest_density_code                = state_reg.hiden_code;
  assign o_doubled_phase_encoding_allowed      = state_reg.mid_dens_ok;
  assign o_low_rate_range                      = state_reg.gen_a_en_low_rate;
  assign o_general_options_a                   = state_reg.opt_gen_a;
  assign o_general_options_b                   = state_reg.opt_gen_b;

  // assertions
  sequence s_dens_write;
    i_wr && i_addr == `TOBD_OFF_DENS;
  endsequence

  a_emul_decode: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_wr && i_addr == `TOBD_OFF_EMUL |=> ##1 o_emulation == $past(i_wdata[6:5], 2)) // RL1
    else $error("emulation decode mismatch");
  a_ramp_slow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_wr && i_addr == `TOBD_OFF_EMUL && i_wdata[4:3] == 2'h3 ##1 !i_wr |=>
    o_ramp_read_cycles == RAMP8_CYC && o_ramp_write_cycles == RAMP120_CYC) // RL2
    else $error("slow ramp values wrong");
  a_ramp_none: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    state_reg.opt_emul[4:3] == 2'h0 && $stable(state_reg.opt_emul) |=>
    o_ramp_read_cycles == 24'h000000) // RL2
    else $error("zero ramp not zero");
  a_rate_high: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !state_reg.opt_range[7] && state_reg.opt_emul[2:0] == 3'h7 |=>
    o_host_rate_kbps == 11'h4E2) // RL3
    else $error("high table top rate wrong");
  a_rate_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    state_reg.opt_range[7] && state_reg.opt_emul[2:0] == 3'h0 |=>
    o_host_rate_kbps == 11'h00A) // RL4
    else $error("low table bottom rate wrong");
  a_la_upper: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    state_reg.opt_la[7:4] == 4'h0) // RL5
    else $error("look-ahead upper bits set");
  a_la_never: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    $past(i_resetn) && state_reg.opt_la[3:0] == 4'h0 |=>
    o_lookahead_stop_marks == 8'hFF) // RL6
    else $error("zero termination not 255");
  a_la_count: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    state_reg.opt_la[3:0] != 4'h0 |=>
    o_lookahead_stop_marks == {4'h0, $past(state_reg.opt_la[3:0])}) // RL7
    else $error("termination count wrong");
  a_dens_bits: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_dens_write ##1 !i_wr |=> o_alt_command_set == $past(i_wdata[3], 2) &&
    o_high_speed_select_line_swapped == $past(i_wdata[2], 2)) // RL8 RL9
    else $error("density select bits wrong");
  a_alt_code: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    s_dens_write ##1 !i_wr |=> (o_highest_density_code == 5'h17) == $past(i_wdata[4], 2) &&
    o_doubled_phase_encoding_allowed == !$past(i_wdata[4], 2)) // RL10 RL11
    else $error("alternate density code wrong");
  a_read_back: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_rd && i_addr == `TOBD_OFF_RANGE |=> o_low_rate_range == o_rdata[7] || $past(i_wr)) // RL12
    else $error("range bit readback mismatch");

  // decoded fields track the stored bytes one cycle later
  a_emul_follow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL1
    $past(i_resetn) |->
    o_emulation == $past(state_reg.opt_emul[`TOBD_EMUL_HI:`TOBD_EMUL_LO]))
    else $error("emulation does not follow stored byte");

  a_ramp_two: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL2
    state_reg.opt_emul[4:3] == 2'h1 |=>
    o_ramp_read_cycles == RAMP2_CYC && o_ramp_write_cycles == RAMP2_CYC)
    else $error("2 ms ramp values wrong");

  a_ramp_four: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL2
    state_reg.opt_emul[4:3] == 2'h2 |=>
    o_ramp_read_cycles == RAMP4_CYC && o_ramp_write_cycles == RAMP4_CYC)
    else $error("4 ms ramp values wrong");

  a_ramp_zero_wr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL2
    state_reg.opt_emul[4:3] == 2'h0 |=> o_ramp_write_cycles == 24'h000000)
    else $error("zero write ramp not zero");

  a_rate_low_top: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL4
    state_reg.opt_range[7] && state_reg.opt_emul[2:0] == 3'h7 |=>
    o_host_rate_kbps == 11'h0C1)
    else $error("low table top rate wrong");

  a_rate_high_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL3
    !state_reg.opt_range[7] && state_reg.opt_emul[2:0] == 3'h0 |=>
    o_host_rate_kbps == 11'h116)
    else $error("high table bottom rate wrong");

  a_la_read: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL5
    i_rd && i_addr == `TOBD_OFF_LOOKAHEAD |=> o_rdata[7:4] == 4'h0)
    else $error("look-ahead upper bits read back");

  a_la_limits: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL7
    $past(i_resetn) |->
    o_lookahead_stop_marks == 8'hFF ||
    (o_lookahead_stop_marks[7:4] == 4'h0 && o_lookahead_stop_marks != 8'h00))
    else $error("termination count out of range");

  a_cmdset_follow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL8
    $past(i_resetn) |->
    o_alt_command_set == $past(state_reg.opt_dens[`TOBD_DENS_CMDSET_BIT]))
    else $error("command set select does not follow");

  a_swap_pair: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL9
    o_high_speed_select_line_swapped == o_high_density_indicator_line_swapped)
    else $error("pin swap flags disagree");

  a_std_code: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL10 RL11
    $past(i_resetn) && !$past(state_reg.opt_dens[`TOBD_DENS_ALTHI_BIT]) |->
    o_highest_density_code == 5'h18 && o_doubled_phase_encoding_allowed)
    else $error("standard density code wrong");

  a_alt_no_mid: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL11
    $past(state_reg.opt_dens[`TOBD_DENS_ALTHI_BIT]) |->
    o_highest_density_code == 5'h17 && !o_doubled_phase_encoding_allowed)
    else $error("third density still offered");

  a_range_follow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL12
    $past(i_resetn) |->
    o_low_rate_range == $past(state_reg.opt_range[`TOBD_RANGE_BIT]))
    else $error("range flag does not follow");

  a_gen_a_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL12
    i_wr && i_addr == `TOBD_OFF_GEN_A |=> o_general_options_a == $past(i_wdata))
    else $error("general options a not stored");

  a_gen_b_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL12
    i_wr && i_addr == `TOBD_OFF_GEN_B |=> o_general_options_b == $past(i_wdata))
    else $error("general options b not stored");

  a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL13
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data left standing");

  a_unmapped_rd: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL13
    i_rd && (i_addr < `TOBD_OFF_HOST_A || i_addr > `TOBD_OFF_GEN_B) |=>
    o_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_emul_store: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RL13
    i_wr && i_addr == `TOBD_OFF_EMUL |=> state_reg.opt_emul == $past(i_wdata))
    else $error("emulation byte not stored");
endmodule : tobd_option_decoder

// >>> tape_option_byte_decoder_tb.sv
module tape_option_byte_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 i_clk_sys;
  logic                 i_resetn;
  logic [7:0]           i_addr;
  logic [7:0]           i_wdata;
  logic                 i_wr;
  logic                 i_rd;
  logic [7:0]           o_rdata;
  tobd_pkg::tobd_emul_t o_emulation;
  logic [23:0]          o_ramp_rd;
  logic [23:0]          o_ramp_wr;
  logic [10:0]          o_rate;
  logic [7:0]           o_la;
  logic                 o_alt;
  logic                 o_swap_hs;
  logic                 o_swap_hd;
  logic [4:0]           o_hcode;
  logic                 o_dbl_phase_ok;
  logic                 o_low;
  logic [7:0]           o_gen_a;
  logic [7:0]           o_gen_b;
  int                   n_mismatch;
  int                   n_tests;
  localparam logic [10:0] HI_T [8] = '{11'h116, 11'h138, 11'h165, 11'h1A0,
                                       11'h1F4, 11'h271, 11'h341, 11'h4E2};
  localparam logic [10:0] LO_T [8] = '{11'h00A, 11'h01E, 11'h032, 11'h048,
                                       11'h064, 11'h078, 11'h09C, 11'h0C1};
  localparam logic [23:0] RD_T [4] = '{24'h0, 24'h50, 24'hA0, 24'h140};
  localparam logic [23:0] WR_T [4] = '{24'h0, 24'h50, 24'hA0, 24'h12C0};
  tobd_option_decoder #(.CLK_KHZ(40)) dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_emulation(o_emulation),
    .o_ramp_read_cycles(o_ramp_rd), .o_ramp_write_cycles(o_ramp_wr),
    .o_host_rate_kbps(o_rate), .o_lookahead_stop_marks(o_la),
    .o_alt_command_set(o_alt), .o_high_speed_select_line_swapped(o_swap_hs),
    .o_high_density_indicator_line_swapped(o_swap_hd), .o_highest_density_code(o_hcode),
    .o_doubled_phase_encoding_allowed(o_dbl_phase_ok), .o_low_rate_range(o_low),
    .o_general_options_a(o_gen_a), .o_general_options_b(o_gen_b));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr   <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    check(24'(o_rdata), 24'(exp));
    @(negedge i_clk_sys);
    check(24'(o_rdata), 24'h0);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : settle
  task automatic do_reset();
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    settle();
    check(24'(o_emulation), 24'h0);
    check(o_ramp_rd, 24'h0);
    check(24'(o_rate), 24'h116);
    check(24'(o_la), 24'hFF);
    check(24'(o_hcode), 24'h18);
    check(24'(o_dbl_phase_ok), 24'h1);
    $display("test reset done");
  endtask : do_reset
  task automatic t_emul_ramp();
    for (int e = 0; e < 4; e++) begin
      for (int r = 0; r < 4; r++) begin
        wr(8'h0F, {1'b0, 2'(e), 2'(r), 3'h0});
        settle();
        check(24'(o_emulation), 24'(e));
        check(o_ramp_rd, RD_T[r]);
        check(o_ramp_wr, WR_T[r]);
      end
    end
    $display("test emulation and ramp done");
  endtask : t_emul_ramp
  task automatic t_rates();
    for (int g = 0; g < 2; g++) begin
      wr(8'h0E, {1'(g), 7'h0});
      for (int c = 0; c < 8; c++) begin
        wr(8'h0F, {5'h0, 3'(c)});
        settle();
        check(24'(o_low), 24'(g));
        check(24'(o_rate), 24'(g ? LO_T[c] : HI_T[c]));
      end
    end
    wr(8'h0E, 8'h00);
    $display("test rates done");
  endtask : t_rates
  task automatic t_lookahead();
    logic [7:0] v [4];
    logic [7:0] e [4];
    v = '{8'h00, 8'h01, 8'h0F, 8'hF7};
    e = '{8'hFF, 8'h01, 8'h0F, 8'h07};
    for (int k = 0; k < 4; k++) begin
      wr(8'h11, v[k]);
      settle();
      check(24'(o_la), 24'(e[k]));
      rd(8'h11, v[k] & 8'h0F);
    end
    $display("test lookahead done");
  endtask : t_lookahead
  task automatic t_density();
    logic [7:0] d;
    for (int k = 0; k < 8; k++) begin
      d = {3'h0, 3'(k), 2'h0};
      wr(8'h10, d);
      settle();
      check(24'(o_alt), 24'(d[3]));
      check(24'(o_swap_hs), 24'(d[2]));
      check(24'(o_swap_hd), 24'(d[2]));
      check(24'(o_hcode), d[4] ? 24'h17 : 24'h18);
      check(24'(o_dbl_phase_ok), 24'(!d[4]));
    end
    $display("test density done");
  endtask : t_density
  task automatic t_regs();
    logic [7:0] a;
    for (int k = 6; k <= 18; k++) begin
      a = 8'(k);
      if (a != 8'h11 && a != 8'h0E && a != 8'h0F) begin
        wr(a, 8'h5A ^ a);
        rd(a, 8'h5A ^ a);
      end
    end
    settle();
    check(24'(o_gen_a), 24'(8'h5A ^ 8'h0D));
    check(24'(o_gen_b), 24'(8'h5A ^ 8'h12));
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    n_mismatch++;
    conclude();
  end
  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    i_resetn   = 1'b0;
    i_addr     = 8'h00;
    i_wdata    = 8'h00;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    do_reset();
    t_emul_ramp();
    t_rates();
    t_lookahead();
    t_density();
    t_regs();
    do_reset();
    conclude();
  end
endmodule : tape_option_byte_decoder_tb
